// *** verilog/rsm_pkg.sv ***
// shared constants and types for the reverse / supplemental mode controller
package rsm_pkg;
  // register offsets
  localparam logic [7:0] REG_GATE_PUMP_OFS   = 8'h39;
  localparam logic [7:0] REG_FEATURE_MON_OFS = 8'h3C;
  localparam logic [7:0] REG_REV_VOLT_OFS    = 8'h49;
  localparam logic [7:0] REG_ADC_PROT_OFS    = 8'h4C;
  localparam logic [7:0] REG_CMP_ALERT_OFS   = 8'h4E;
  localparam logic [7:0] REG_REV_CURR_OFS    = 8'h4A;
  localparam logic [7:0] REG_LIVE_STATUS_OFS = 8'h4F;
  localparam logic [7:0] REG_IRQ_CLEAR_OFS   = 8'h4D;
  // reset values
  localparam logic [15:0] RST_GATE_PUMP   = 16'h0000;
  localparam logic [15:0] RST_FEATURE_MON = 16'h0000;
  localparam logic [15:0] RST_REV_VOLT    = 16'h0A70;
  localparam logic [15:0] RST_ADC_PROT    = 16'h0000;
  localparam logic [15:0] RST_CMP_ALERT   = 16'h0000;
  localparam logic [15:0] RST_REV_CURR    = 16'h0200;
  // field positions
  localparam int GP_SHIP_ADAPTER_OFF = 12;
  localparam int FM_REV_FUNC_BIT     = 11;
  localparam int FM_SUP_BIT          = 10;
  localparam int FM_LOW_RAIL_LO      = 0;
  localparam int CA_GPCMP_DISABLE    = 3;
  localparam int AP_UV_DISABLE       = 15;
  localparam int CA_PG_IRQ_EN        = 0;
  localparam logic [15:0] REV_VOLT_MASK = 16'h7FF8;
  localparam logic [15:0] REV_CURR_MASK = 16'h1FE0;
  localparam logic [15:0] REV_CURR_MAX  = 16'h17E0;
  // timing
  localparam int CLK_MHZ            = 125;
  localparam int START_DELAY_NS     = 1000;
  localparam int START_DELAY_CYC    = (START_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int OV_RESTART_US      = 100;
  localparam int OV_RESTART_CYC     = OV_RESTART_US * CLK_MHZ;
  localparam int SUP_ALERT_NS       = 369000;
  localparam int SUP_ALERT_CYC      = SUP_ALERT_NS * CLK_MHZ / 1000;
  localparam int TMR_W              = 17;

  typedef struct packed {
    logic bat_above_2v7;
    logic adp_below_3v2;
    logic bat_above_5v2;
    logic in_below_rev_ovp;
    logic out_reached_target;
    logic out_below_uv;
    logic out_above_ov;
    logic in_below_target;
    logic rail_below_low;
    logic in_below_out_400m;
    logic battery_absent;
    logic fast_role_swap;
  } rsm_cmp_type;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_DELAY = 5'b00010,
    ST_RUN   = 5'b00100,
    ST_OV    = 5'b01000,
    ST_SHIP  = 5'b10000
  } rsm_state_type;
endpackage

// *** verilog/rsm_mode_ctrl.sv ***
// reverse, ship and supplemental mode controller
// Overview of operation
// - battery-only when battery above 2.7V and adapter below 3.2V.
// - battery-only drives battery gate and adapter path gate on, except in ship state.
// - ship state entered only from battery-only mode.
// - ship state left on adapter detect or host rewriting control bits.
// - reverse only with register enable, pin enable when comparator disable bit 3 set, and battery above 5.2V.
// - switching after short delay; power-good once output reaches target.
// - power-good latched on interrupt pin until cleared; live status readable.
// - hold switching until input below target plus 100mV.
// - undervoltage at target minus 1.2V, overvoltage at plus 1.2V.
// - undervoltage ignored when adc register bit 15 set.
// - overvoltage stops switching, drops power-good; restart 100us after clear.
// - reverse refused while battery-absent high.
// - voltage register resets to 5.004V, accepts any value.
// - current register resets to 512mA, keeps valid bits, clamps at 6112mA.
// - fast role swap waits until input falls below target.
// - supplemental low rail bucks from input caps and asserts throttle alert.
// - alert after 369us or input below output plus 400mV; no debounce.
// - enable pin decode truth table for reverse and supplemental.
`timescale 1ns/1ps
`default_nettype none
module rsm_mode_ctrl
  import rsm_pkg::*;
#(
  parameter int OV_RESTART_CYCLES = OV_RESTART_CYC,
  parameter int SUP_ALERT_CYCLES  = SUP_ALERT_CYC
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic [15:0]      reg_rdata,
  // asynchronous inputs
  input  wire rsm_cmp_type cmp_async,
  input  wire logic        shared_enable_comparator_pin,
  // outputs
  output logic             battery_gate,
  output logic             adapter_path_gate,
  output logic             reverse_switching,
  output logic             supplemental_buck,
  output logic             reverse_power_good,
  output logic             irq_n,
  output logic             throttle_alert_n_oe,
  output logic             ship_mode
);
  rsm_cmp_type   cmp_s1_q, cmp_q;
  logic          pin_s1_q, pin_q;
  logic [15:0]   gate_q, feat_q, volt_q, adc_q, cmpa_q, curr_q;
  logic          pg_latch_q, pg_q, alert_q, ship_q, pg_prev_q;
  logic [TMR_W-1:0] tmr_q, sup_tmr_q;
  rsm_state_type st_q, st_d;
  logic [TMR_W-1:0] tmr_d;

  // two-stage synchronisers
  always_ff @(posedge core_clk) begin
    cmp_s1_q <= cmp_async;
    cmp_q    <= cmp_s1_q;
    pin_s1_q <= shared_enable_comparator_pin;
    pin_q    <= pin_s1_q;
  end

  // decode
  wire wr_gate = reg_wr && reg_addr == REG_GATE_PUMP_OFS;
  wire wr_feat = reg_wr && reg_addr == REG_FEATURE_MON_OFS;
  wire wr_volt = reg_wr && reg_addr == REG_REV_VOLT_OFS;
  wire wr_adc  = reg_wr && reg_addr == REG_ADC_PROT_OFS;
  wire wr_cmpa = reg_wr && reg_addr == REG_CMP_ALERT_OFS;
  wire wr_curr = reg_wr && reg_addr == REG_REV_CURR_OFS;
  wire wr_clr  = reg_wr && reg_addr == REG_IRQ_CLEAR_OFS;
  wire ctrl_wr = wr_gate | wr_feat | wr_adc | wr_cmpa;

  wire [15:0] curr_masked = reg_wdata & REV_CURR_MASK;
  wire [15:0] curr_wval   = (curr_masked > REV_CURR_MAX) ? REV_CURR_MAX : curr_masked;

  // enable pin decode
  wire gpc_disabled = cmpa_q[CA_GPCMP_DISABLE];
  wire rev_bit      = feat_q[FM_REV_FUNC_BIT];
  wire sup_bit      = feat_q[FM_SUP_BIT];
  wire rev_req = gpc_disabled ? (pin_q && rev_bit) : rev_bit;
  wire sup_en  = gpc_disabled && pin_q && sup_bit && !rev_bit;

  wire battery_only = cmp_q.bat_above_2v7 && cmp_q.adp_below_3v2;
  wire rev_allowed  = rev_req && cmp_q.bat_above_5v2 && !cmp_q.battery_absent;
  wire uv_fault     = cmp_q.out_below_uv && !adc_q[AP_UV_DISABLE];
  wire input_clear  = cmp_q.in_below_rev_ovp &&
                      (!cmp_q.fast_role_swap || cmp_q.in_below_target);
  wire ship_req     = gate_q[GP_SHIP_ADAPTER_OFF] && !rev_req && !sup_en;
  wire tmr_zero     = tmr_q == '0;

  // reverse sequence
  always_comb begin
    st_d  = st_q;
    tmr_d = tmr_zero ? tmr_q : tmr_q - 1'b1;
    unique case (st_q)
      ST_IDLE: begin
        if (rev_allowed) begin
          st_d  = ST_DELAY;
          tmr_d = TMR_W'(START_DELAY_CYC);
        end else if (battery_only && ship_req) begin
          st_d = ST_SHIP;
        end
      end
      ST_DELAY: begin
        if (!rev_allowed) begin
          st_d = ST_IDLE;
        end else if (tmr_zero && input_clear) begin
          st_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!rev_allowed) begin
          st_d = ST_IDLE;
        end else if (cmp_q.out_above_ov) begin
          st_d  = ST_OV;
          tmr_d = TMR_W'(OV_RESTART_CYCLES);
        end
      end
      ST_OV: begin
        if (!rev_allowed) begin
          st_d = ST_IDLE;
        end else if (cmp_q.out_above_ov) begin
          tmr_d = TMR_W'(OV_RESTART_CYCLES);
        end else if (tmr_zero) begin
          st_d = ST_RUN;
        end
      end
      ST_SHIP: begin
        if (!cmp_q.adp_below_3v2 || ctrl_wr) begin
          st_d = ST_IDLE;
        end
      end
    endcase
  end

  wire pg_live = st_q == ST_RUN && cmp_q.out_reached_target && !uv_fault;
  wire low_rail_sup = sup_en && cmp_q.rail_below_low;
  wire sup_timeout  = sup_tmr_q >= TMR_W'(SUP_ALERT_CYCLES);
  wire alert_d      = low_rail_sup && (sup_timeout || cmp_q.in_below_out_400m);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      gate_q <= RST_GATE_PUMP;
      feat_q <= RST_FEATURE_MON;
      volt_q <= RST_REV_VOLT;
      adc_q  <= RST_ADC_PROT;
      cmpa_q <= RST_CMP_ALERT;
      curr_q <= RST_REV_CURR;
    end else begin
      if (wr_gate) gate_q <= reg_wdata;
      if (wr_feat) feat_q <= reg_wdata;
      if (wr_volt) volt_q <= reg_wdata;
      if (wr_adc)  adc_q  <= reg_wdata;
      if (wr_cmpa) cmpa_q <= reg_wdata;
      if (wr_curr) curr_q <= curr_wval;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q       <= ST_IDLE;
      tmr_q      <= '0;
      pg_q       <= 1'b0;
      pg_prev_q  <= 1'b0;
      pg_latch_q <= 1'b0;
      sup_tmr_q  <= '0;
      alert_q    <= 1'b0;
      ship_q     <= 1'b0;
    end else begin
      st_q      <= st_d;
      tmr_q     <= tmr_d;
      pg_q      <= pg_live;
      pg_prev_q <= pg_q;
      // set wins over a clear in the same cycle
      pg_latch_q <= (pg_q && !pg_prev_q) || (pg_latch_q && !wr_clr);
      // no debounce here: supplemental hold-up must throttle at once
      if (!low_rail_sup) begin
        sup_tmr_q <= '0;
      end else if (!sup_timeout) begin
        sup_tmr_q <= sup_tmr_q + 1'b1;
      end
      alert_q <= alert_d;
      ship_q  <= st_d == ST_SHIP;
    end
  end

  // outputs
  wire in_batt_only = battery_only && st_q != ST_SHIP;
  assign battery_gate        = in_batt_only;
  assign adapter_path_gate   = in_batt_only;
  assign reverse_switching   = st_q == ST_RUN;
  assign supplemental_buck   = low_rail_sup;
  assign reverse_power_good  = pg_q;
  assign irq_n               = !(pg_latch_q && cmpa_q[CA_PG_IRQ_EN]);
  assign throttle_alert_n_oe = alert_q;
  assign ship_mode           = ship_q;

  // read mux; unmapped addresses read zero
  wire [15:0] live_status = {11'h000, ship_q, alert_q, sup_en, pg_latch_q, pg_q};
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        REG_GATE_PUMP_OFS:   reg_rdata <= gate_q;
        REG_FEATURE_MON_OFS: reg_rdata <= feat_q;
        REG_REV_VOLT_OFS:    reg_rdata <= volt_q;
        REG_ADC_PROT_OFS:    reg_rdata <= adc_q;
        REG_CMP_ALERT_OFS:   reg_rdata <= cmpa_q;
        REG_REV_CURR_OFS:    reg_rdata <= curr_q;
        REG_LIVE_STATUS_OFS: reg_rdata <= live_status;
        default:             reg_rdata <= 16'h0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** bench/rsm_monitor.sv ***
// port checker for the mode controller
`timescale 1ns/1ps
`default_nettype none
module rsm_monitor import rsm_pkg::*; #(parameter int OV_RESTART_CYCLES = OV_RESTART_CYC) (
  // clock, reset, register port
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_rdata,
  // mode signals
  input wire rsm_cmp_type cmp_async,
  input wire logic        reverse_switching,
  input wire logic        supplemental_buck,
  input wire logic        reverse_power_good
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [15:0] ov_cnt_q;
  logic        trip_q;
  // trip marks a stop caused by overvoltage, so a first start is not timed as a restart
  always_ff @(posedge core_clk) begin
    ov_cnt_q <= (rst || cmp_async.out_above_ov) ? 16'h0000 : ov_cnt_q + {15'h0000, ~&ov_cnt_q};
    trip_q <= !rst && (trip_q && !reverse_switching ||
      $fell(reverse_switching) && cmp_async.out_above_ov);
  end
  rev_batlow_a: assert property ((!cmp_async.bat_above_5v2)[*5] |-> !reverse_switching)
    else $error("reverse with low battery");
  rev_absent_a: assert property (cmp_async.battery_absent[*5] |-> !reverse_switching)
    else $error("reverse with battery absent");
  ov_stop_a: assert property (cmp_async.out_above_ov[*5] |-> !reverse_switching && !reverse_power_good)
    else $error("no stop on overvoltage");
  ov_wait_a: assert property ($rose(reverse_switching) && trip_q |-> ov_cnt_q >= OV_RESTART_CYCLES)
    else $error("restart too early");
  pg_run_a: assert property (reverse_power_good |-> $past(reverse_switching))
    else $error("power good without switching");
  pg_cause_a: assert property ($rose(reverse_power_good) |-> $past(cmp_async.out_reached_target, 2))
    else $error("power good without target");
  sup_excl_a: assert property (supplemental_buck |-> !reverse_switching)
    else $error("supplemental during reverse");
  unmapped_rd_a: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
endmodule
bind rsm_mode_ctrl rsm_monitor #(.OV_RESTART_CYCLES(OV_RESTART_CYCLES)) mon_u (.core_clk, .rst,
  .reg_rd, .reg_addr, .reg_rdata, .cmp_async, .reverse_switching, .supplemental_buck,
  .reverse_power_good);
`default_nettype wire

// *** bench/rsm_host_model.sv ***
// host model: register port driver and ship-state programming
`timescale 1ns/1ps
`default_nettype none
module rsm_host_model (
  // clock
  input  wire logic        core_clk,
  // register port
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [7:0]       reg_addr,
  output logic [15:0]      reg_wdata,
  input  wire logic [15:0] reg_rdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge core_clk);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask
  // extra cycle before sampling: read data is registered
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge core_clk);
    {reg_rd, reg_addr} = {1'b1, a};
    @(negedge core_clk);
    reg_rd = 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask
  // gate register last: any later control write would leave ship again
  task automatic ship_setup();
    wr(8'h3C, 16'h0060);
    wr(8'h4C, 16'h0000);
    wr(8'h4E, 16'h1000);
    wr(8'h39, 16'h1000);
  endtask
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench for the mode controller
`timescale 1ns/1ps
`default_nettype none
module tb_top import rsm_pkg::*;;
  logic core_clk, rst, reg_wr, reg_rd, pin, battery_gate, adapter_path_gate, reverse_switching;
  logic supplemental_buck, reverse_power_good, irq_n, throttle_alert_n_oe, ship_mode;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  rsm_cmp_type cmp_async;
  int err_total, total_checks, n;
  rsm_mode_ctrl #(.OV_RESTART_CYCLES(20), .SUP_ALERT_CYCLES(30)) dut_u (.core_clk, .rst,
    .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .cmp_async,
    .shared_enable_comparator_pin(pin), .battery_gate, .adapter_path_gate, .reverse_switching,
    .supplemental_buck, .reverse_power_good, .irq_n, .throttle_alert_n_oe, .ship_mode);
  rsm_host_model host_u (.core_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk({15'h0000, g}, {15'h0000, e});
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
    host_u.rd(a, d);
    chk(d, e);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wait_sw(input int lim);
    n = 0;
    while (reverse_switching !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
    if (n >= lim) begin
      err_total++;
      print_verdict();
    end
  endtask
  task automatic t_regs();
    rdchk(8'h49, RST_REV_VOLT);
    rdchk(8'h4A, RST_REV_CURR);
    host_u.wr(8'h4A, 16'hFFFF);
    rdchk(8'h4A, REV_CURR_MAX);
    host_u.wr(8'h4A, 16'h0A5F);
    rdchk(8'h4A, 16'h0A5F & REV_CURR_MASK);
    rdchk(8'h00, 16'h0000);
    $display("registers done");
  endtask
  task automatic t_ship();
    cmp_async.bat_above_2v7 = 1'b1;
    cmp_async.adp_below_3v2 = 1'b1;
    cyc(5);
    chk1(battery_gate & adapter_path_gate, 1'b1);
    host_u.ship_setup();
    cyc(5);
    chk1(ship_mode, 1'b1);
    cmp_async.adp_below_3v2 = 1'b0;
    cyc(5);
    chk1(ship_mode, 1'b0);
    host_u.wr(8'h3C, 16'h0000);
    host_u.wr(8'h39, 16'h0000);
    $display("ship done");
  endtask
  task automatic t_rev();
    host_u.wr(8'h4E, 16'h0009);
    host_u.wr(8'h3C, 16'h0800);
    {cmp_async.bat_above_5v2, cmp_async.in_below_rev_ovp, cmp_async.in_below_target} = 3'h7;
    pin = 1'b1;
    wait_sw(300);
    chk1(n > START_DELAY_CYC, 1'b1);
    cmp_async.out_reached_target = 1'b1;
    cyc(6);
    chk1(reverse_power_good & ~irq_n, 1'b1);
    rdchk(8'h4F, 16'h0003);
    host_u.wr(8'h4D, 16'h0001);
    cyc(2);
    chk1(irq_n, 1'b1);
    cmp_async.out_below_uv = 1'b1;
    cyc(6);
    chk1(reverse_power_good, 1'b0);
    host_u.wr(8'h4C, 16'h8000);
    cyc(6);
    chk1(reverse_power_good, 1'b1);
    cmp_async.out_below_uv = 1'b0;
    host_u.wr(8'h4C, 16'h0000);
    cmp_async.out_above_ov = 1'b1;
    cyc(6);
    chk1(reverse_switching | reverse_power_good, 1'b0);
    cmp_async.out_above_ov = 1'b0;
    wait_sw(60);
    chk1(n >= 20, 1'b1);
    cmp_async.battery_absent = 1'b1;
    cyc(6);
    chk1(reverse_switching, 1'b0);
    {cmp_async.battery_absent, pin} = 2'b00;
    cmp_async.in_below_rev_ovp = 1'b0;
    host_u.wr(8'h4E, 16'h0001);
    cyc(150);
    chk1(reverse_switching, 1'b0);
    cmp_async.in_below_rev_ovp = 1'b1;
    {cmp_async.fast_role_swap, cmp_async.in_below_target} = 2'b10;
    cyc(20);
    chk1(reverse_switching, 1'b0);
    cmp_async.in_below_target = 1'b1;
    wait_sw(300);
    chk1(n <= 5, 1'b1);
    cmp_async.fast_role_swap = 1'b0;
    host_u.wr(8'h3C, 16'h0000);
    cyc(6);
    chk1(reverse_switching, 1'b0);
    $display("reverse done");
  endtask
  task automatic t_sup();
    host_u.wr(8'h4E, 16'h0008);
    {cmp_async.bat_above_5v2, cmp_async.rail_below_low, pin} = 3'b011;
    for (int i = 0; i < 4; i++) begin
      host_u.wr(8'h3C, {4'h0, i[1:0], 10'h000});
      cyc(6);
      chk1(supplemental_buck, i == 1);
      if (i == 1) begin
        chk1(throttle_alert_n_oe, 1'b0);
        cyc(40);
        chk1(throttle_alert_n_oe, 1'b1);
      end
    end
    host_u.wr(8'h3C, 16'h0400);
    cmp_async.in_below_out_400m = 1'b1;
    cyc(6);
    chk1(throttle_alert_n_oe, 1'b1);
    cmp_async.in_below_out_400m = 1'b0;
    host_u.wr(8'h3C, 16'h0000);
    $display("supplemental done");
  endtask
  initial begin
    {rst, pin, cmp_async, err_total, total_checks} = {2'b10, 12'h000, 64'h0};
    cyc(10);
    rst = 1'b0;
    t_regs();
    t_ship();
    t_rev();
    t_sup();
    print_verdict();
  end
endmodule
`default_nettype wire
